// ===== rtl/bsosc_pkg.sv
// Shared constants, power states and control bundle for the burst SRAM output and sleep block
package bsosc_pkg;

   localparam int BSOSC_ADDR_W  = 17;
   localparam int BSOSC_LANES   = 2;
   localparam int BSOSC_LANE_W  = 9;
   localparam int BSOSC_DATA_W  = BSOSC_LANES * BSOSC_LANE_W;

   // Sleep entry delay and cycles spent in the waking state, in clock cycles
   localparam int BSOSC_SLEEP_ENTRY_DELAY = 2;
   localparam int BSOSC_SLEEP_EXIT_DELAY  = 2;
   // Entry delay is spent in the two-stage sleep synchroniser
   localparam int BSOSC_SLEEP_SYNC_STAGES = BSOSC_SLEEP_ENTRY_DELAY;
   localparam int BSOSC_WAKE_CNT_W        = 2;
   localparam logic [BSOSC_WAKE_CNT_W-1:0] BSOSC_WAKE_LAST =
      BSOSC_WAKE_CNT_W'(BSOSC_SLEEP_EXIT_DELAY - 1);
   localparam logic [BSOSC_WAKE_CNT_W-1:0] BSOSC_WAKE_ZERO = 2'h0;
   localparam logic [BSOSC_WAKE_CNT_W-1:0] BSOSC_WAKE_ONE  = 2'h1;

   typedef enum logic [2:0] {
      BSOSC_PWR_AWAKE  = 3'h1,
      BSOSC_PWR_ASLEEP = 3'h2,
      BSOSC_PWR_WAKING = 3'h4
   } bsosc_pwr_t;

   typedef struct packed {
      logic                   processor_address_strobe_n;
      logic                   controller_address_strobe_n;
      logic                   global_write_n;
      logic                   byte_write_gate_n;
      logic [BSOSC_LANES-1:0] lane_write_n;
      logic                   primary_select_n;
      logic                   bank_select_high;
      logic                   bank_select_low_n;
   } bsosc_ctl_t;

endpackage : bsosc_pkg

// ===== rtl/bsosc_core.sv
// Burst SRAM core: select and write decode, pass-through, output drive and sleep control
`timescale 1ns/1ps

// Operation
// - Write on global strobe or gated lane strobes
// - Selected only with all three selects active
// - Output enable drives or floats read data
// - Sleep floats all data pins
// - Deselected floats data pins regardless of enable
// - Read after full write forwards written data
// - Read after lane write forwards that lane
// - Idle after write shows written data once
// - Deselected idle after write stays floating
// - Sleep entry takes two cycles, exit takes five
// - Outputs on two cycles, off one cycle
// - Opposite-polarity selects allow two-bank depth
// - Global write strobe writes every lane
// - Sampled lane write disables output drivers
// - Sleep keeps state, resumes after wake time
// - Memory holds 128K words of 18 bits
module bsosc_core
   import bsosc_pkg::*;
#(
   parameter int ADDR_W = BSOSC_ADDR_W
) (
   input  wire logic                    SYS_CLK_IN,
   input  wire logic                    RST_IN,
   input  wire logic [ADDR_W-1:0]       ADDR_IN,
   input  wire logic                    PROCESSOR_ADDRESS_STROBE_N_IN,
   input  wire logic                    CONTROLLER_ADDRESS_STROBE_N_IN,
   input  wire logic                    GLOBAL_WRITE_N_IN,
   input  wire logic                    BYTE_WRITE_GATE_N_IN,
   input  wire logic [BSOSC_LANES-1:0]  LANE_WRITE_N_IN,
   input  wire logic                    PRIMARY_SELECT_N_IN,
   input  wire logic                    BANK_SELECT_HIGH_IN,
   input  wire logic                    BANK_SELECT_LOW_N_IN,
   input  wire logic                    OUTPUT_ENABLE_N_IN,
   input  wire logic                    SLEEP_REQUEST_IN,
   input  wire logic [BSOSC_DATA_W-1:0] DATA_IN,
   output logic      [BSOSC_DATA_W-1:0] DATA_OUT,
   output logic      [BSOSC_DATA_W-1:0] DATA_OE_OUT,
   output logic                         AWAKE_OUT
);

   localparam int DEPTH = 1 << ADDR_W;

   bsosc_ctl_t ctl;

   logic [BSOSC_DATA_W-1:0] rd_word;

   logic                    sleep_meta_reg;
   logic                    sleep_sync_reg;
   bsosc_pwr_t              pwr_reg;
   bsosc_pwr_t              pwr_next;
   logic [BSOSC_WAKE_CNT_W-1:0] wake_cnt_reg;
   logic [BSOSC_WAKE_CNT_W-1:0] wake_cnt_next;

   logic                    active_reg;
   logic                    active_next;
   logic [ADDR_W-1:0]       addr_reg;
   logic [ADDR_W-1:0]       addr_next;
   logic                    rd_pend_reg;
   logic                    rd_pend_next;
   logic [BSOSC_LANES-1:0]  wlanes_reg;
   logic [BSOSC_LANES-1:0]  wlanes_next;
   logic [BSOSC_DATA_W-1:0] wdata_reg;
   logic [BSOSC_DATA_W-1:0] wdata_next;
   logic [BSOSC_DATA_W-1:0] dout_reg;
   logic [BSOSC_DATA_W-1:0] dout_next;
   logic [BSOSC_LANES-1:0]  drive_reg;
   logic [BSOSC_LANES-1:0]  drive_next;

   logic                    awake;
   logic                    selected;
   logic                    proc_start;
   logic                    start;
   logic                    deselect;
   logic                    wr_window;
   logic [BSOSC_LANES-1:0]  wr_mask;
   logic [BSOSC_LANES-1:0]  wr_lanes;
   logic [ADDR_W-1:0]       wr_addr;

   assign ctl = '{
      processor_address_strobe_n:  PROCESSOR_ADDRESS_STROBE_N_IN,
      controller_address_strobe_n: CONTROLLER_ADDRESS_STROBE_N_IN,
      global_write_n:              GLOBAL_WRITE_N_IN,
      byte_write_gate_n:           BYTE_WRITE_GATE_N_IN,
      lane_write_n:                LANE_WRITE_N_IN,
      primary_select_n:            PRIMARY_SELECT_N_IN,
      bank_select_high:            BANK_SELECT_HIGH_IN,
      bank_select_low_n:           BANK_SELECT_LOW_N_IN
   };

   // Power state
   always_comb begin
      pwr_next      = pwr_reg;
      wake_cnt_next = wake_cnt_reg;
      case (pwr_reg)
         BSOSC_PWR_AWAKE: begin
            if (sleep_sync_reg) begin
               pwr_next = BSOSC_PWR_ASLEEP;
            end
         end
         BSOSC_PWR_ASLEEP: begin
            if (!sleep_sync_reg) begin
               pwr_next      = BSOSC_PWR_WAKING;
               wake_cnt_next = BSOSC_WAKE_ZERO;
            end
         end
         BSOSC_PWR_WAKING: begin
            if (sleep_sync_reg) begin
               pwr_next = BSOSC_PWR_ASLEEP;
            end else if (wake_cnt_reg == BSOSC_WAKE_LAST) begin
               pwr_next = BSOSC_PWR_AWAKE;
            end else begin
               wake_cnt_next = wake_cnt_reg + BSOSC_WAKE_ONE;
            end
         end
         default: begin
            pwr_next = BSOSC_PWR_AWAKE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         sleep_meta_reg <= 1'b0;
         sleep_sync_reg <= 1'b0;
         pwr_reg        <= BSOSC_PWR_AWAKE;
         wake_cnt_reg   <= BSOSC_WAKE_ZERO;
      end else begin
         sleep_meta_reg <= SLEEP_REQUEST_IN;
         sleep_sync_reg <= sleep_meta_reg;
         pwr_reg        <= pwr_next;
         wake_cnt_reg   <= wake_cnt_next;
      end
   end

   // Sleep synchroniser output floats pins two edges after the request rises
   assign awake     = (pwr_reg == BSOSC_PWR_AWAKE) && !sleep_sync_reg;
   assign AWAKE_OUT = awake;

   // Select and write decode
   always_comb begin
      selected   = !ctl.primary_select_n && ctl.bank_select_high
                   && !ctl.bank_select_low_n;
      proc_start = !ctl.processor_address_strobe_n && !ctl.primary_select_n;
      start      = proc_start || !ctl.controller_address_strobe_n;
      deselect   = start && !selected;
      if (!ctl.global_write_n) begin
         wr_mask = '1;
      end else if (!ctl.byte_write_gate_n) begin
         wr_mask = ~ctl.lane_write_n;
      end else begin
         wr_mask = '0;
      end
      wr_window = (start && selected && !proc_start) || (!start && active_reg);
      wr_lanes  = wr_window ? wr_mask : '0;
      wr_addr   = start ? ADDR_IN : addr_reg;
   end

   // Access pipeline, pass-through and drive
   always_comb begin
      active_next  = active_reg;
      addr_next    = addr_reg;
      rd_pend_next = rd_pend_reg;
      wlanes_next  = wlanes_reg;
      wdata_next   = wdata_reg;
      dout_next    = dout_reg;
      drive_next   = drive_reg;
      if (awake) begin
         active_next  = deselect ? 1'b0 : (start ? 1'b1 : active_reg);
         addr_next    = (start && selected) ? ADDR_IN : addr_reg;
         rd_pend_next = ((start && selected) || (!start && active_reg)) && !(|wr_lanes);
         wlanes_next  = wr_lanes;
         wdata_next   = DATA_IN;
         if (|(~ctl.lane_write_n) || (|wr_lanes)) begin
            drive_next = '0;
         end else if (deselect) begin
            drive_next = '0;
         end else if (|wlanes_reg) begin
            for (int i = 0; i < BSOSC_LANES; i++) begin
               if (wlanes_reg[i]) begin
                  dout_next[i*BSOSC_LANE_W +: BSOSC_LANE_W] =
                     wdata_reg[i*BSOSC_LANE_W +: BSOSC_LANE_W];
               end
            end
            drive_next = wlanes_reg;
         end else if (rd_pend_reg) begin
            dout_next  = rd_word;
            drive_next = '1;
         end else begin
            drive_next = '0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         active_reg  <= 1'b0;
         addr_reg    <= '0;
         rd_pend_reg <= 1'b0;
         wlanes_reg  <= '0;
         wdata_reg   <= '0;
         dout_reg    <= '0;
         drive_reg   <= '0;
      end else begin
         active_reg  <= active_next;
         addr_reg    <= addr_next;
         rd_pend_reg <= rd_pend_next;
         wlanes_reg  <= wlanes_next;
         wdata_reg   <= wdata_next;
         dout_reg    <= dout_next;
         drive_reg   <= drive_next;
      end
   end

   // Storage array, one write enable per lane, frozen while asleep
   genvar g;
   generate
      for (g = 0; g < BSOSC_LANES; g++) begin : g_lane
         // Each lane owns its array so only one process writes it
         logic [BSOSC_LANE_W-1:0] lane_mem [DEPTH];
         always_ff @(posedge SYS_CLK_IN) begin
            if (awake && wr_lanes[g]) begin
               lane_mem[wr_addr] <= DATA_IN[g*BSOSC_LANE_W +: BSOSC_LANE_W];
            end
         end
         assign rd_word[g*BSOSC_LANE_W +: BSOSC_LANE_W] = lane_mem[addr_reg];
         // Output enable acts without the clock
         assign DATA_OE_OUT[g*BSOSC_LANE_W +: BSOSC_LANE_W] =
            {BSOSC_LANE_W{drive_reg[g] && awake && !OUTPUT_ENABLE_N_IN}};
      end
   endgenerate

   assign DATA_OUT = dout_reg;

endmodule : bsosc_core

// ===== testbench/bsosc_core_asserts.sv
// Pin-level assertions for the burst SRAM output and sleep block
`timescale 1ns/1ps
module bsosc_core_asserts
   import bsosc_pkg::*;
(
   input wire logic                    SYS_CLK_IN,
   input wire logic                    RST_IN,
   input wire logic                    PROCESSOR_ADDRESS_STROBE_N_IN,
   input wire logic                    CONTROLLER_ADDRESS_STROBE_N_IN,
   input wire logic                    GLOBAL_WRITE_N_IN,
   input wire logic                    BYTE_WRITE_GATE_N_IN,
   input wire logic [BSOSC_LANES-1:0]  LANE_WRITE_N_IN,
   input wire logic                    PRIMARY_SELECT_N_IN,
   input wire logic                    BANK_SELECT_HIGH_IN,
   input wire logic                    BANK_SELECT_LOW_N_IN,
   input wire logic                    OUTPUT_ENABLE_N_IN,
   input wire logic                    SLEEP_REQUEST_IN,
   input wire logic [BSOSC_DATA_W-1:0] DATA_IN,
   input wire logic [BSOSC_DATA_W-1:0] DATA_OUT,
   input wire logic [BSOSC_DATA_W-1:0] DATA_OE_OUT,
   input wire logic                    AWAKE_OUT
);
   wire st  = !CONTROLLER_ADDRESS_STROBE_N_IN
              || (!PROCESSOR_ADDRESS_STROBE_N_IN && !PRIMARY_SELECT_N_IN);
   wire sel = !PRIMARY_SELECT_N_IN && BANK_SELECT_HIGH_IN && !BANK_SELECT_LOW_N_IN;
   wire wr  = !GLOBAL_WRITE_N_IN || (!BYTE_WRITE_GATE_N_IN && LANE_WRITE_N_IN != 2'h3);
   wire rd  = sel && !PROCESSOR_ADDRESS_STROBE_N_IN && AWAKE_OUT;
   wire fw  = sel && !CONTROLLER_ADDRESS_STROBE_N_IN && PROCESSOR_ADDRESS_STROBE_N_IN
              && !GLOBAL_WRITE_N_IN && AWAKE_OUT;
   wire idl = !st && !wr && LANE_WRITE_N_IN == 2'h3 && !OUTPUT_ENABLE_N_IN && AWAKE_OUT;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   oe_float_a: assert property (OUTPUT_ENABLE_N_IN |-> DATA_OE_OUT == 18'h0)
      else $error("drive with output enable high");
   sleep_hiz_a: assert property (!AWAKE_OUT |-> DATA_OE_OUT == 18'h0)
      else $error("drive while asleep");
   desel_off_a: assert property (st && !sel && AWAKE_OUT |=> DATA_OE_OUT == 18'h0)
      else $error("drive after deselect");
   read_on_a: assert property (rd ##1 idl ##1 (!OUTPUT_ENABLE_N_IN && AWAKE_OUT)
      |-> DATA_OE_OUT == 18'h3ffff) else $error("read data not driven");
   pass_all_a: assert property (fw ##1 idl ##1 (!OUTPUT_ENABLE_N_IN && AWAKE_OUT)
      |-> DATA_OE_OUT == 18'h3ffff && DATA_OUT == $past(DATA_IN, 2))
      else $error("written word not passed through");
   write_off_a: assert property (fw && !$past(wr) |=> DATA_OE_OUT == 18'h0)
      else $error("drive after sampled write");
   sleep_entry_a: assert property ($rose(SLEEP_REQUEST_IN) |-> ##[1:2] !AWAKE_OUT)
      else $error("sleep entry late");
   sleep_exit_a: assert property ($fell(SLEEP_REQUEST_IN) && !AWAKE_OUT
      |-> !AWAKE_OUT [*2] ##[1:6] AWAKE_OUT) else $error("wake timing wrong");
   cover property (fw ##1 idl);
   cover property (rd ##1 idl);
   cover property ($fell(SLEEP_REQUEST_IN) ##[1:8] AWAKE_OUT);
endmodule : bsosc_core_asserts

// ===== testbench/bsosc_ctl_model.sv
// Cache-controller model driving the burst SRAM pins
`timescale 1ns/1ps
module bsosc_ctl_model
   import bsosc_pkg::*;
(
   input  wire logic                    clk_in,
   output bsosc_ctl_t                   ctl_out,
   output logic      [5:0]              addr_out,
   output logic      [BSOSC_DATA_W-1:0] data_out,
   output logic                         oe_n_out,
   output logic                         sleep_out
);
   initial begin
      ctl_out = bsosc_ctl_t'(9'h1fa);
      addr_out = 6'h05;
      data_out = 18'h0;
      oe_n_out = 1'b1;
      sleep_out = 1'b0;
   end
   // Holds one cycle of pins from a falling edge to the next
   task automatic op(input logic [8:0] c, input logic [17:0] d, input logic oe);
      logic w;
      w = !c[6] || (!c[5] && c[4:3] != 2'h3);
      ctl_out = bsosc_ctl_t'(c);
      oe_n_out = w ? 1'b1 : oe;
      data_out = w ? d : ~data_out;
      @(negedge clk_in);
   endtask : op
   task automatic nap(input logic v);
      sleep_out = v;
   endtask : nap
   task automatic at(input logic [5:0] a);
      addr_out = a;
   endtask : at
endmodule : bsosc_ctl_model

// ===== testbench/burst_sram_output_sleep_control_tb_top.sv
// Testbench for the burst SRAM output and sleep block
`timescale 1ns/1ps
module burst_sram_output_sleep_control_tb_top
   import bsosc_pkg::*;
;
   logic       SYS_CLK_IN;
   logic       RST_IN;
   bsosc_ctl_t ctl;
   logic [5:0] addr;
   logic [17:0] din, dout, doe;
   logic       oe_n, zz, awake;
   int         errors = 0;
   int         checked = 0;
   bsosc_ctl_model bsosc_ctl_model_inst (.clk_in(SYS_CLK_IN), .ctl_out(ctl),
      .addr_out(addr), .data_out(din), .oe_n_out(oe_n), .sleep_out(zz));
   bsosc_core #(.ADDR_W(6)) bsosc_core_inst (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
      .ADDR_IN(addr), .PROCESSOR_ADDRESS_STROBE_N_IN(ctl.processor_address_strobe_n),
      .CONTROLLER_ADDRESS_STROBE_N_IN(ctl.controller_address_strobe_n),
      .GLOBAL_WRITE_N_IN(ctl.global_write_n), .BYTE_WRITE_GATE_N_IN(ctl.byte_write_gate_n),
      .LANE_WRITE_N_IN(ctl.lane_write_n), .PRIMARY_SELECT_N_IN(ctl.primary_select_n),
      .BANK_SELECT_HIGH_IN(ctl.bank_select_high), .BANK_SELECT_LOW_N_IN(ctl.bank_select_low_n),
      .OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(zz), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE_OUT(doe), .AWAKE_OUT(awake));
   initial begin
      SYS_CLK_IN = 1'b0;
      forever #10 SYS_CLK_IN = ~SYS_CLK_IN;
   end
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task automatic op(input logic [8:0] c, input logic [17:0] d, input logic oe);
      bsosc_ctl_model_inst.op(c, d, oe);
   endtask : op
   // Full write, pass-through, read back, then a single-lane write followed by a read
   task automatic t_write;
      op(9'h13a, 18'h2a5c3, 1'b0);
      op(9'h1fa, 18'h0, 1'b0);
      check("pass data", dout, 18'h2a5c3);
      check("pass oe", doe, 18'h3ffff);
      op(9'h0fa, 18'h0, 1'b0);
      op(9'h1fa, 18'h0, 1'b0);
      check("read data", dout, 18'h2a5c3);
      op(9'h1fa, 18'h0, 1'b1);
      check("oe high", doe, 18'h0);
      op(9'h14a, 18'h1b7e4, 1'b0);
      op(9'h0fa, 18'h0, 1'b0);
      check("lane oe", doe, 18'h3fe00);
      check("lane data", {dout[17:9], 9'h0}, 18'h1b600);
      op(9'h1fa, 18'h0, 1'b0);
      check("merged word", dout, 18'h1b7c3);
   endtask : t_write
   // Forwarding to a new read address, lane 0 write, deselect after write
   task automatic t_addr;
      bsosc_ctl_model_inst.at(6'h09);
      op(9'h13a, 18'h0c3a5, 1'b0);
      bsosc_ctl_model_inst.at(6'h05);
      op(9'h0fa, 18'h0, 1'b0);
      check("fwd data", dout, 18'h0c3a5);
      check("fwd oe", doe, 18'h3ffff);
      op(9'h1fa, 18'h0, 1'b0);
      check("new word", dout, 18'h1b7c3);
      bsosc_ctl_model_inst.at(6'h09);
      op(9'h152, 18'h00155, 1'b0);
      bsosc_ctl_model_inst.at(6'h05);
      op(9'h0fa, 18'h0, 1'b0);
      check("lane0 oe", doe, 18'h001ff);
      check("lane0 data", {9'h0, dout[8:0]}, 18'h00155);
      op(9'h1fa, 18'h0, 1'b0);
      check("lane0 next", dout, 18'h1b7c3);
      bsosc_ctl_model_inst.at(6'h09);
      op(9'h0fa, 18'h0, 1'b0);
      op(9'h1fa, 18'h0, 1'b0);
      check("lane0 word", dout, 18'h0c355);
      op(9'h13a, 18'h0c355, 1'b0);
      op(9'h17e, 18'h0, 1'b1);
      check("desel hiz", doe, 18'h0);
      op(9'h1fa, 18'h0, 1'b0);
      check("no carry", doe, 18'h0);
      bsosc_ctl_model_inst.at(6'h05);
   endtask : t_addr
   task automatic t_desel;
      logic [8:0] pat [3] = '{9'h17e, 9'h178, 9'h17b};
      foreach (pat[i]) begin
         op(9'h0fa, 18'h0, 1'b0);
         op(9'h1fa, 18'h0, 1'b0);
         op(pat[i], 18'h0, 1'b0);
         check("deselect oe", doe, 18'h0);
      end
   endtask : t_desel
   task automatic t_sleep;
      int n;
      op(9'h0fa, 18'h0, 1'b0);
      bsosc_ctl_model_inst.nap(1'b1);
      repeat (3) op(9'h1fa, 18'h0, 1'b0);
      check("sleep oe", doe, 18'h0);
      check("sleep flag", 18'(awake), 18'h0);
      bsosc_ctl_model_inst.nap(1'b0);
      n = 0;
      while (awake !== 1'b1 && n < 20) begin
         op(9'h1fa, 18'h0, 1'b1);
         n++;
      end
      if (n == 20) begin
         errors++;
      end else begin
         check("wake time", 18'(n >= 2), 18'h1);
         op(9'h0fa, 18'h0, 1'b0);
         op(9'h1fa, 18'h0, 1'b0);
         check("kept word", dout, 18'h1b7c3);
      end
   endtask : t_sleep
   initial begin
      RST_IN = 1'b1;
      repeat (16) @(negedge SYS_CLK_IN);
      RST_IN = 1'b0;
      t_write();
      t_addr();
      t_desel();
      t_sleep();
      finish_test();
   end
endmodule : burst_sram_output_sleep_control_tb_top
bind bsosc_core bsosc_core_asserts bsosc_core_asserts_inst (.*);
